// File: hdl/lacb_bank.sv
// Limit and alert configuration registers with the comparators they steer.
// Assumes host logic presents word writes/reads and measurement results with a valid strobe.
`default_nettype none
// Notes on behaviour
// - Bus result below warning limit sets warning flag and, if enabled, the warning pin.
// - Power result above power limit sets its flag and, if enabled, over-limit pin.
// - Bus result above high limit sets its flag and, if enabled, over-limit pin.
// - Bus result below low over-limit sets its flag and, if enabled, over-limit pin.
// - Over-limit polarity bit: one asserts high, zero asserts low, default zero.
// - Over-limit latch bit: one latches, zero transparent, default zero.
// - Positive critical threshold is an unsigned byte in millivolts.
// - Readback bit shows the present aux pin level.
// - Aux mode: 00/01 released input, 10 drives low, 11 drives high.
// - Critical open-drain polarity: one active high, zero active low.
// - Hysteresis equals the three-bit code times two millivolts.
// - Critical latch bit: one latches, zero transparent, default zero.
// - Negative critical threshold is a byte magnitude below zero in millivolts.
// - Critical filter time equals code times 64 microseconds.
// - Warning pin assertion delayed by code times 100 milliseconds.
// - Calibration bit zero reads zero and ignores writes.
// - Stored calibration value drives current and power scaling.
// - The warning delay applies to warning pin assertion from limit comparisons.
module lacb_bank #(
   parameter int FILT_CYC = lacb_pkg::FILT_STEP_CYC,
   parameter int WDLY_CYC = lacb_pkg::WDLY_STEP_CYC
) (
   input  wire logic                              i_clk,
   input  wire logic                              i_rst,
   input  wire logic                              i_reg_wr,
   input  wire logic                              i_reg_rd,
   input  wire logic [lacb_pkg::ADDR_W-1:0]       i_reg_addr,
   input  wire logic [lacb_pkg::DATA_W-1:0]       i_reg_wdata,
   output logic      [lacb_pkg::DATA_W-1:0]       o_reg_rdata,
   input  wire logic                              i_meas_valid,
   input  wire logic [lacb_pkg::DATA_W-1:0]       i_bus_result,
   input  wire logic [lacb_pkg::DATA_W-1:0]       i_power_result,
   input  wire logic signed [lacb_pkg::SHUNT_W-1:0] i_shunt_mv,
   input  wire logic                              i_warn_output_enable,
   input  wire logic                              i_overlimit_output_enable,
   input  wire logic                              i_warn_polarity,
   input  wire logic                              i_clr_bus_low_warn,
   input  wire logic                              i_clr_power_ovl,
   input  wire logic                              i_clr_bus_high_ovl,
   input  wire logic                              i_clr_bus_low_ovl,
   input  wire logic                              i_clr_critical,
   input  wire logic                              i_aux_pin,
   output logic                                   o_aux_pin_o,
   output logic                                   o_aux_pin_oe,
   output logic                                   o_bus_low_warn_flag,
   output logic                                   o_power_ovl_flag,
   output logic                                   o_bus_high_overlimit_flag,
   output logic                                   o_bus_low_overlimit_flag,
   output logic                                   o_critical_flag,
   output logic                                   o_warn_pin,
   output logic                                   o_overlimit_pin,
   output logic                                   o_crit_pin_o,
   output logic                                   o_crit_pin_oe,
   output logic      [14:0]                       o_scale_value
);
   import lacb_pkg::*;

   localparam int TH_W = SHUNT_W + 1;

   function automatic logic [12:0] bus_field(input logic [15:0] w);
      bus_field = w[BUS_FIELD_MSB:BUS_FIELD_LSB];
   endfunction

   function automatic logic signed [TH_W-1:0] mv_ext(input logic [7:0] b);
      mv_ext = $signed({{(TH_W-8){1'b0}}, b});
   endfunction

   // Register storage
   logic [15:0] bus_low_warn_limit_q;
   logic [15:0] power_overlimit_value_q;
   logic [15:0] bus_high_overlimit_cfg_q;
   logic [15:0] bus_low_overlimit_value_q;
   logic [15:0] critical_positive_cfg_q;
   logic [15:0] critical_negative_cfg_q;
   logic [15:0] scale_calibration_q;
   logic        aux_level_q;

   // Field views
   logic [12:0] bus_low_warn_field;
   logic [15:0] power_overlimit_field;
   logic [12:0] bus_high_overlimit_field;
   logic [12:0] bus_low_overlimit_field;
   logic        overlimit_polarity;
   logic        overlimit_latch_select;
   logic [7:0]  critical_pos_threshold;
   logic [7:0]  critical_neg_threshold;
   logic [1:0]  aux_pin_mode;
   logic        critical_polarity;
   logic [2:0]  critical_hysteresis;
   logic        critical_latch_select;
   logic [3:0]  critical_filter_time;
   logic [3:0]  warn_delay_time;

   assign bus_low_warn_field       = bus_field(bus_low_warn_limit_q);
   assign power_overlimit_field    = power_overlimit_value_q;
   assign bus_high_overlimit_field = bus_field(bus_high_overlimit_cfg_q);
   assign bus_low_overlimit_field  = bus_field(bus_low_overlimit_value_q);
   assign overlimit_polarity       = bus_high_overlimit_cfg_q[OVL_POL_BIT];
   assign overlimit_latch_select   = bus_high_overlimit_cfg_q[OVL_LATCH_BIT];
   assign critical_pos_threshold   = critical_positive_cfg_q[THR_MSB:THR_LSB];
   assign critical_neg_threshold   = critical_negative_cfg_q[THR_MSB:THR_LSB];
   assign aux_pin_mode             = critical_positive_cfg_q[AUX_MODE_MSB:AUX_MODE_LSB];
   assign critical_polarity        = critical_positive_cfg_q[CRIT_POL_BIT];
   assign critical_hysteresis      = critical_positive_cfg_q[HYST_MSB:HYST_LSB];
   assign critical_latch_select    = critical_positive_cfg_q[CRIT_LATCH_BIT];
   assign critical_filter_time     = critical_negative_cfg_q[FILT_MSB:FILT_LSB];
   assign warn_delay_time          = critical_negative_cfg_q[WDLY_MSB:WDLY_LSB];

   // Write decode
   logic wr_warn, wr_pov, wr_bho, wr_blo, wr_cpos, wr_cneg, wr_cal;
   assign wr_warn = i_reg_wr && (i_reg_addr == ADDR_BUS_LOW_WARN);
   assign wr_pov  = i_reg_wr && (i_reg_addr == ADDR_POWER_OVL);
   assign wr_bho  = i_reg_wr && (i_reg_addr == ADDR_BUS_HIGH_OVL);
   assign wr_blo  = i_reg_wr && (i_reg_addr == ADDR_BUS_LOW_OVL);
   assign wr_cpos = i_reg_wr && (i_reg_addr == ADDR_CRIT_POS);
   assign wr_cneg = i_reg_wr && (i_reg_addr == ADDR_CRIT_NEG);
   assign wr_cal  = i_reg_wr && (i_reg_addr == ADDR_SCALE_CAL);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         bus_low_warn_limit_q      <= RST_WORD;
         power_overlimit_value_q   <= RST_WORD;
         bus_high_overlimit_cfg_q  <= RST_WORD;
         bus_low_overlimit_value_q <= RST_WORD;
         critical_positive_cfg_q   <= RST_WORD;
         critical_negative_cfg_q   <= RST_WORD;
         scale_calibration_q       <= RST_WORD;
      end else begin
         if (wr_warn) bus_low_warn_limit_q      <= i_reg_wdata;
         if (wr_pov)  power_overlimit_value_q   <= i_reg_wdata;
         if (wr_bho)  bus_high_overlimit_cfg_q  <= i_reg_wdata;
         if (wr_blo)  bus_low_overlimit_value_q <= i_reg_wdata;
         if (wr_cpos) critical_positive_cfg_q   <= i_reg_wdata;
         if (wr_cneg) critical_negative_cfg_q   <= i_reg_wdata;
         if (wr_cal)  scale_calibration_q       <= i_reg_wdata & SCALE_WMASK;
      end
   end

   // Aux pin level sampled every clock, so readback follows the pin after reset
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) aux_level_q <= 1'b0;
      else       aux_level_q <= i_aux_pin;
   end

   // Read path
   logic [15:0] rd_mux;
   logic [15:0] crit_pos_read;
   assign crit_pos_read = {critical_positive_cfg_q[15:8], aux_level_q, critical_positive_cfg_q[6:0]};
   always_comb begin
      case (i_reg_addr)
         ADDR_BUS_LOW_WARN: rd_mux = bus_low_warn_limit_q;
         ADDR_POWER_OVL:    rd_mux = power_overlimit_value_q;
         ADDR_BUS_HIGH_OVL: rd_mux = bus_high_overlimit_cfg_q;
         ADDR_BUS_LOW_OVL:  rd_mux = bus_low_overlimit_value_q;
         ADDR_CRIT_POS:     rd_mux = crit_pos_read;
         ADDR_CRIT_NEG:     rd_mux = critical_negative_cfg_q;
         ADDR_SCALE_CAL:    rd_mux = scale_calibration_q & SCALE_WMASK;
         default:           rd_mux = RST_WORD;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst)         o_reg_rdata <= RST_WORD;
      else if (i_reg_rd) o_reg_rdata <= rd_mux;
   end

   // Calibration word toward the measurement engine
   assign o_scale_value = scale_calibration_q[SCALE_MSB:SCALE_LSB];

   // Aux pin drive
   assign o_aux_pin_oe = (aux_pin_mode == LACB_AUX_LOW) || (aux_pin_mode == LACB_AUX_HIGH);
   assign o_aux_pin_o  = (aux_pin_mode == LACB_AUX_HIGH);

   // Limit comparisons, evaluated on each new measurement
   logic warn_cmp, pov_cmp, bho_cmp, blo_cmp;
   assign warn_cmp = bus_field(i_bus_result) < bus_low_warn_field;
   assign pov_cmp  = i_power_result > power_overlimit_field;
   assign bho_cmp  = bus_field(i_bus_result) > bus_high_overlimit_field;
   assign blo_cmp  = bus_field(i_bus_result) < bus_low_overlimit_field;

   logic warn_cond_q, ovl_cond_q;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         warn_cond_q <= 1'b0;
         ovl_cond_q  <= 1'b0;
      end else if (i_meas_valid) begin
         warn_cond_q <= warn_cmp;
         ovl_cond_q  <= pov_cmp || bho_cmp || blo_cmp;
      end
   end

   // Sticky status flags; a new set wins over a same-cycle clear
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_bus_low_warn_flag       <= 1'b0;
         o_power_ovl_flag          <= 1'b0;
         o_bus_high_overlimit_flag <= 1'b0;
         o_bus_low_overlimit_flag  <= 1'b0;
      end else begin
         o_bus_low_warn_flag       <= (i_meas_valid && warn_cmp) || (o_bus_low_warn_flag && !i_clr_bus_low_warn);
         o_power_ovl_flag          <= (i_meas_valid && pov_cmp) || (o_power_ovl_flag && !i_clr_power_ovl);
         o_bus_high_overlimit_flag <= (i_meas_valid && bho_cmp) ||
                                      (o_bus_high_overlimit_flag && !i_clr_bus_high_ovl);
         o_bus_low_overlimit_flag  <= (i_meas_valid && blo_cmp) ||
                                      (o_bus_low_overlimit_flag && !i_clr_bus_low_ovl);
      end
   end

   // Warning pin with programmable assertion delay
   logic warn_qual;
   lacb_qual_timer #(
      .STEP_CYC (WDLY_CYC),
      .CNT_W    (24)
   ) u_warn_delay (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_cond (warn_cond_q),
      .i_code (warn_delay_time),
      .o_qual (warn_qual)
   );

   logic warn_active;
   assign warn_active = i_warn_output_enable && warn_qual;

   // Over-limit pin: latched form follows the sticky flags until cleared
   logic ovl_flags_any, ovl_active;
   assign ovl_flags_any = o_power_ovl_flag || o_bus_high_overlimit_flag || o_bus_low_overlimit_flag;
   assign ovl_active    = i_overlimit_output_enable &&
                          (overlimit_latch_select ? ovl_flags_any : ovl_cond_q);

   // Critical comparator with hysteresis
   logic signed [TH_W-1:0] shunt_x, pos_thr, neg_thr, hyst_mv;
   logic                   crit_raw_q, crit_trip, crit_hold;
   assign shunt_x   = TH_W'(i_shunt_mv);
   assign pos_thr   = mv_ext(critical_pos_threshold);
   assign neg_thr   = -mv_ext(critical_neg_threshold);
   assign hyst_mv   = $signed(TH_W'(critical_hysteresis) * TH_W'(HYST_STEP_MV));
   assign crit_trip = (shunt_x > pos_thr) || (shunt_x < neg_thr);
   assign crit_hold = (shunt_x > (pos_thr - hyst_mv)) || (shunt_x < (neg_thr + hyst_mv));

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) crit_raw_q <= 1'b0;
      else       crit_raw_q <= crit_raw_q ? crit_hold : crit_trip;
   end

   logic crit_filt;
   lacb_qual_timer #(
      .STEP_CYC (FILT_CYC),
      .CNT_W    (16)
   ) u_crit_filter (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_cond (crit_raw_q),
      .i_code (critical_filter_time),
      .o_qual (crit_filt)
   );

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) o_critical_flag <= 1'b0;
      else       o_critical_flag <= crit_filt || (o_critical_flag && !i_clr_critical);
   end

   logic crit_active;
   assign crit_active = critical_latch_select ? o_critical_flag : crit_filt;

   // Pin outputs, registered except o_crit_pin_o, which is tied low
   logic crit_level;
   assign crit_level = crit_active ? critical_polarity : !critical_polarity;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_warn_pin      <= 1'b1;
         o_overlimit_pin <= 1'b1;
         o_crit_pin_oe   <= 1'b0;
      end else begin
         o_warn_pin      <= warn_active ? i_warn_polarity : !i_warn_polarity;
         o_overlimit_pin <= ovl_active ? overlimit_polarity : !overlimit_polarity;
         o_crit_pin_oe   <= !crit_level;
      end
   end
   assign o_crit_pin_o = 1'b0;

   // Checks
   property p_warn_flag;
      @(posedge i_clk) disable iff (i_rst)
      i_meas_valid && warn_cmp |=> o_bus_low_warn_flag;
   endproperty
   a_warn_flag: assert property (p_warn_flag) else $error("warning flag not set");

   property p_power_flag;
      @(posedge i_clk) disable iff (i_rst)
      i_meas_valid && (i_power_result > power_overlimit_value_q) |=> o_power_ovl_flag;
   endproperty
   a_power_flag: assert property (p_power_flag) else $error("power flag not set");

   property p_high_flag;
      @(posedge i_clk) disable iff (i_rst)
      i_meas_valid && (i_bus_result[15:3] > bus_high_overlimit_cfg_q[15:3]) |=> o_bus_high_overlimit_flag;
   endproperty
   a_high_flag: assert property (p_high_flag) else $error("bus high flag not set");

   property p_low_flag;
      @(posedge i_clk) disable iff (i_rst)
      i_meas_valid && (i_bus_result[15:3] < bus_low_overlimit_value_q[15:3]) |=> o_bus_low_overlimit_flag;
   endproperty
   a_low_flag: assert property (p_low_flag) else $error("bus low flag not set");

   property p_ovl_polarity;
      @(posedge i_clk) disable iff (i_rst)
      i_overlimit_output_enable && !overlimit_latch_select && ovl_cond_q && !wr_bho
         |=> o_overlimit_pin == bus_high_overlimit_cfg_q[1];
   endproperty
   a_ovl_polarity: assert property (p_ovl_polarity) else $error("over-limit pin level wrong");

   property p_ovl_latch_hold;
      @(posedge i_clk) disable iff (i_rst)
      i_overlimit_output_enable && overlimit_latch_select && ovl_flags_any && !wr_bho
         |=> o_overlimit_pin == overlimit_polarity;
   endproperty
   a_ovl_latch_hold: assert property (p_ovl_latch_hold) else $error("latched over-limit dropped");

   property p_aux_drive;
      @(posedge i_clk) disable iff (i_rst)
      critical_positive_cfg_q[6] |-> o_aux_pin_oe && (o_aux_pin_o == critical_positive_cfg_q[5]);
   endproperty
   a_aux_drive: assert property (p_aux_drive) else $error("aux pin drive mismatch");

   property p_aux_read;
      @(posedge i_clk) disable iff (i_rst)
      i_reg_rd && (i_reg_addr == ADDR_CRIT_POS) ##1 !i_rst |-> o_reg_rdata[7] == $past(aux_level_q);
   endproperty
   a_aux_read: assert property (p_aux_read) else $error("aux readback mismatch");

   property p_cal_void;
      @(posedge i_clk) disable iff (i_rst)
      i_reg_rd && (i_reg_addr == ADDR_SCALE_CAL) |=> o_reg_rdata[0] == 1'b0;
   endproperty
   a_cal_void: assert property (p_cal_void) else $error("calibration bit zero read as one");

   property p_cal_out;
      @(posedge i_clk) disable iff (i_rst)
      wr_cal |=> o_scale_value == $past(i_reg_wdata[15:1]);
   endproperty
   a_cal_out: assert property (p_cal_out) else $error("calibration value not forwarded");

   property p_crit_trip;
      @(posedge i_clk) disable iff (i_rst)
      (shunt_x > pos_thr) |=> crit_raw_q;
   endproperty
   a_crit_trip: assert property (p_crit_trip) else $error("critical comparator missed trip");

   property p_crit_pin;
      @(posedge i_clk) disable iff (i_rst)
      crit_active && !critical_polarity && !wr_cpos |=> o_crit_pin_oe;
   endproperty
   a_crit_pin: assert property (p_crit_pin) else $error("active-low critical pin not pulled");
endmodule
`default_nettype wire

// File: hdl/lacb_pkg.sv
// Package for the limit and alert configuration bank.
// Assumes a single 100 MHz clock and word-wide register access by the host logic.
`default_nettype none
package lacb_pkg;
   localparam int          DATA_W         = 16;
   localparam int          ADDR_W         = 8;
   localparam int          SHUNT_W        = 10;
   localparam int          CODE_W         = 4;

   // Register pointers
   localparam logic [7:0]  ADDR_BUS_LOW_WARN  = 8'h10;
   localparam logic [7:0]  ADDR_POWER_OVL     = 8'h11;
   localparam logic [7:0]  ADDR_BUS_HIGH_OVL  = 8'h12;
   localparam logic [7:0]  ADDR_BUS_LOW_OVL   = 8'h13;
   localparam logic [7:0]  ADDR_CRIT_POS      = 8'h14;
   localparam logic [7:0]  ADDR_CRIT_NEG      = 8'h15;
   localparam logic [7:0]  ADDR_SCALE_CAL     = 8'h16;

   // Reset values
   localparam logic [15:0] RST_WORD           = 16'h0000;

   // Field positions
   localparam int          BUS_FIELD_LSB      = 3;
   localparam int          BUS_FIELD_MSB      = 15;
   localparam int          OVL_POL_BIT        = 1;
   localparam int          OVL_LATCH_BIT      = 0;
   localparam int          THR_MSB            = 15;
   localparam int          THR_LSB            = 8;
   localparam int          AUX_READ_BIT       = 7;
   localparam int          AUX_MODE_MSB       = 6;
   localparam int          AUX_MODE_LSB       = 5;
   localparam int          CRIT_POL_BIT       = 4;
   localparam int          HYST_MSB           = 3;
   localparam int          HYST_LSB           = 1;
   localparam int          CRIT_LATCH_BIT     = 0;
   localparam int          FILT_MSB           = 7;
   localparam int          FILT_LSB           = 4;
   localparam int          WDLY_MSB           = 3;
   localparam int          WDLY_LSB           = 0;
   localparam int          SCALE_MSB          = 15;
   localparam int          SCALE_LSB          = 1;
   localparam logic [15:0] SCALE_WMASK        = 16'hfffe;

   // Hysteresis step in mV per code
   localparam int          HYST_STEP_MV       = 2;

   // Timing
   localparam int          CLK_PERIOD_NS      = 10;
   localparam int          FILT_STEP_US       = 64;
   localparam int          WDLY_STEP_MS       = 100;
   localparam int          FILT_STEP_CYC      = (FILT_STEP_US * 1000) / CLK_PERIOD_NS;
   localparam int          WDLY_STEP_CYC      = (WDLY_STEP_MS * 1000000) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      LACB_AUX_IN0  = 2'b00,
      LACB_AUX_IN1  = 2'b01,
      LACB_AUX_LOW  = 2'b10,
      LACB_AUX_HIGH = 2'b11
   } lacb_aux_mode_t;
endpackage
`default_nettype wire

// File: hdl/lacb_qual_timer.sv
// Qualifying delay: output rises once the condition has held code x step cycles.
// Assumes i_cond is a registered level; output falls the cycle after it drops.
`default_nettype none
module lacb_qual_timer #(
   parameter int STEP_CYC = 6400,
   parameter int CNT_W    = 24
) (
   input  wire logic                      i_clk,
   input  wire logic                      i_rst,
   input  wire logic                      i_cond,
   input  wire logic [lacb_pkg::CODE_W-1:0] i_code,
   output logic                           o_qual
);
   import lacb_pkg::*;

   localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYC - 1);

   logic [CNT_W-1:0]  pre_q;
   logic [CODE_W-1:0] steps_q;
   logic              done;
   logic              tick;

   assign done = (steps_q == i_code);
   assign tick = (pre_q == STEP_LAST);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pre_q   <= '0;
         steps_q <= '0;
         o_qual  <= 1'b0;
      end else if (!i_cond) begin
         pre_q   <= '0;
         steps_q <= '0;
         o_qual  <= 1'b0;
      end else if (done) begin
         o_qual  <= 1'b1;
      end else if (tick) begin
         pre_q   <= '0;
         steps_q <= steps_q + CODE_W'(1);
      end else begin
         pre_q   <= pre_q + CNT_W'(1);
      end
   end

   property p_qual_needs_cond;
      @(posedge i_clk) disable iff (i_rst)
      $rose(o_qual) |-> $past(i_cond) && $past(done);
   endproperty
   a_qual_needs_cond: assert property (p_qual_needs_cond) else $error("qualified without held condition");

   property p_qual_drops;
      @(posedge i_clk) disable iff (i_rst)
      !i_cond |=> !o_qual;
   endproperty
   a_qual_drops: assert property (p_qual_drops) else $error("qualified output outlived its condition");
endmodule
`default_nettype wire

// File: tb/lacb_testbench.sv
// Self-checking bench for the limit and alert configuration bank.
// Assumes shortened filter and warning counts, and a bench-held register image.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import lacb_pkg::*;
   logic              i_clk, i_rst, wr, rd, mv, aux, oen, wpol, clr;
   logic [7:0]        addr;
   logic [15:0]       wd, rdata, bus, pwr;
   logic signed [9:0] sh;
   logic              ao, aoe, fw, fp, fh, fl, co, coe, wp, cf, cpo;
   logic [14:0]       scale;
   int                fails, num_checks;
   logic [15:0]       mdl [int];

   lacb_bank #(.FILT_CYC(4), .WDLY_CYC(8)) u_lacb_bank (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(wr),
      .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdata), .i_meas_valid(mv),
      .i_bus_result(bus), .i_power_result(pwr), .i_shunt_mv(sh), .i_warn_output_enable(oen),
      .i_overlimit_output_enable(oen), .i_warn_polarity(wpol), .i_clr_bus_low_warn(clr),
      .i_clr_power_ovl(clr), .i_clr_bus_high_ovl(clr), .i_clr_bus_low_ovl(clr), .i_clr_critical(clr),
      .i_aux_pin(aux), .o_aux_pin_o(ao), .o_aux_pin_oe(aoe), .o_bus_low_warn_flag(fw),
      .o_power_ovl_flag(fp), .o_bus_high_overlimit_flag(fh), .o_bus_low_overlimit_flag(fl),
      .o_critical_flag(cf), .o_warn_pin(wp), .o_overlimit_pin(co), .o_crit_pin_o(cpo), .o_crit_pin_oe(coe),
      .o_scale_value(scale));

   initial begin
      i_clk = 0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic wreg(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk);
      wr <= 1; addr <= a; wd <= d;
      @(posedge i_clk);
      wr <= 0;
      if (mdl.exists(a)) mdl[a] = (a == ADDR_SCALE_CAL) ? (d & 16'hfffe) : d;
      #1;
   endtask

   task automatic rreg(input logic [7:0] a);
      logic [15:0] e;
      e = mdl.exists(a) ? mdl[a] : 16'h0000;
      @(posedge i_clk);
      // Readback shows the pin level sampled at the edge before the read is taken
      if (a == ADDR_CRIT_POS) e[7] = aux;
      rd <= 1; addr <= a;
      @(posedge i_clk);
      rd <= 0;
      #1 chk(rdata, e, "register read");
   endtask

   task automatic meas(input logic [15:0] b, input logic [15:0] p);
      logic [3:0] e;
      e = {b[15:3] < mdl[16][15:3], p > mdl[17], b[15:3] > mdl[18][15:3], b[15:3] < mdl[19][15:3]};
      @(posedge i_clk);
      mv <= 1; bus <= b; pwr <= p;
      @(posedge i_clk);
      mv <= 0;
      #1 chk({fw, fp, fh, fl}, e, "limit flags");
      @(posedge i_clk);
      #1 chk(co, (e[2:0] != 0) ? mdl[18][1] : ~mdl[18][1], "over-limit pin");
      @(posedge i_clk);
      clr <= 1;
      @(posedge i_clk);
      clr <= 0;
   endtask

   task automatic conclude;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      {wr, rd, mv, clr, wpol} = 0; {oen, aux, i_rst} = 3'b111;
      addr = 0; wd = 0; bus = 0; pwr = 0; sh = 0;
      for (int a = 16; a < 23; a++) mdl[a] = 16'h0000;
      void'($urandom(32'h16e4));
      repeat (5) @(posedge i_clk);
      i_rst <= 0;
      for (int a = 16; a < 24; a++) rreg(a[7:0]);
      $display("test reset values done");
      for (int a = 16; a < 24; a++) wreg(a[7:0], 16'($urandom));
      @(posedge i_clk) aux <= 0;
      for (int a = 16; a < 24; a++) rreg(a[7:0]);
      chk({1'b0, scale}, {1'b0, mdl[22][15:1]}, "scale");
      $display("test register access done");
      for (int m = 0; m < 4; m++) begin
         wreg(ADDR_CRIT_POS, 16'(m) << 5);
         chk({aoe, m[1] ? ao : 1'b0}, {m[1], m[1] & m[0]}, "aux drive");
      end
      $display("test aux modes done");
      for (int pol = 0; pol < 2; pol++) begin
         wreg(8'h10, 16'h4000); wreg(8'h11, 16'h1000); wreg(8'h12, 16'h8000 | 16'(pol << 1)); wreg(8'h13, 16'h2000);
         repeat (10) meas(16'($urandom), 16'($urandom));
      end
      $display("test limits done");
      wreg(ADDR_CRIT_POS, 16'h0a00); wreg(ADDR_CRIT_NEG, 16'h0a00);
      @(posedge i_clk) sh <= 10'sd20;
      for (int i = 0; i < 12 && coe !== 1'b1; i++) @(posedge i_clk);
      #1 chk({cpo, coe}, 2'b01, "critical trip");
      @(posedge i_clk) sh <= 10'sd0;
      for (int i = 0; i < 12 && coe !== 1'b0; i++) @(posedge i_clk);
      #1 chk(coe, 1'b0, "critical release");
      chk(cf, 1'b1, "critical flag kept");
      $display("test critical done");
      // Warning delay code 2 is 16 cycles; over-limit latched, active high
      wreg(ADDR_CRIT_NEG, 16'h0002); wreg(ADDR_BUS_HIGH_OVL, 16'h8003);
      @(posedge i_clk) begin
         mv <= 1; bus <= 16'hffff; pwr <= 16'h0000;
      end
      @(posedge i_clk) bus <= 16'h3000;
      @(posedge i_clk) mv <= 0;
      repeat (2) @(posedge i_clk);
      #1 chk(co, 1'b1, "latched over-limit held");
      chk(wp, 1'b1, "warning not yet due");
      @(posedge i_clk) clr <= 1;
      @(posedge i_clk) clr <= 0;
      repeat (2) @(posedge i_clk);
      #1 chk(co, 1'b0, "latched over-limit cleared");
      repeat (11) @(posedge i_clk);
      #1 chk(wp, 1'b1, "warning before delay");
      @(posedge i_clk);
      #1 chk(wp, 1'b0, "warning after delay");
      $display("test latch and warning delay done");
      conclude();
   end
endmodule
`default_nettype wire
